// File: core/fault_record_pkg.sv
// Constants for the fault record block formatter
package fault_record_pkg;
	localparam int        CH_N        = 8;         // Output channels
	localparam int        LOOP_LEN    = 46;        // Bytes in one telemetry loop
	localparam int        RING_LEN    = 166;       // Cyclic region bytes, 72..237
	localparam logic [7:0] ST_BASE    = 8'h30;     // Record byte 48, first status byte
	localparam logic [7:0] CYC_FIRST  = 8'h48;     // Record byte 72
	localparam logic [7:0] CYC_LAST   = 8'hED;     // Record byte 237
	localparam logic [7:0] STREAM_END = 8'hFF;     // Stream index of record byte 254
	localparam logic [7:0] BLK_COUNT  = 8'hFF;     // Block read byte count
	localparam logic [7:0] ALL_VALID  = 8'hFF;     // Valid count when ring is full
	localparam logic [7:0] FILL_BYTE  = 8'h00;     // Reserved and omitted bytes
	localparam logic [5:0] POS_MAX    = 6'h2D;     // Loop position 45
	localparam logic [5:0] VIN_POS    = 6'h0A;     // Input voltage at positions 10..12
	localparam logic [5:0] GRP2_POS   = 6'h0D;     // Channel 2 starts at 13
	localparam logic [5:0] TEMP_POS   = 6'h17;     // Temperature at positions 23..25
	localparam logic [5:0] GRP4_POS   = 6'h1A;     // Channel 4 starts at 26
	localparam logic [5:0] CH_BYTES   = 6'h05;     // Bytes per channel in a loop
	localparam logic [7:0] WI_RESET   = 8'hA5;     // Index 165, so first write lands at 0
	localparam logic [5:0] POS_RESET  = 6'h2D;     // Position 45, so first write is 0
endpackage

// File: core/fault_record_fmt.sv
// Fault record ring capture and block read formatter
// Function
// - Only the low byte of each extended channel status is kept.
// - Preamble is bytes 0..71; bytes 48..71 hold three status bytes per channel.
// - Record byte 72 is the ring entry at the captured newest index.
// - Cyclic bytes run 72..237; bytes 238..254 read as filler.
// - Record bytes count from the first data byte after the count.
// - Block read sends count 0xFF, then the newest index byte.
// - Each later cyclic byte is the entry one loop position lower.
// - A loop holds 46 bytes at positions 0..45.
// - Loop layout: five bytes per channel, input at 10..12, temperature at 23..25.
// - Record byte 0 is the write position captured at the fault.
// - Record byte 1 is the valid cyclic count, 0xFF when all valid.
// - Ring refreshes on every conversion while the lock is clear.
`timescale 1ns/1ps
`default_nettype none
module fault_record_fmt (
	input  wire logic                  clk,        // 100 MHz clock
	input  wire logic                  nrst,       // Async reset, active low
	input  wire logic [7:0][15:0]      vout_rd,    // Output voltage readings
	input  wire logic [7:0][7:0]       vout_st,    // Output voltage status
	input  wire logic [7:0][7:0]       mfr_st,     // Vendor channel status
	input  wire logic [7:0][15:0]      ext_st,     // Extended channel status word
	input  wire logic [15:0]           vin_rd,     // Input voltage reading
	input  wire logic [7:0]            vin_st,     // Input voltage status
	input  wire logic [15:0]           temp_rd,    // Die temperature reading
	input  wire logic [7:0]            temp_st,    // Temperature status
	input  wire logic                  adc_done,   // Conversion complete pulse
	input  wire logic                  fault_trig, // Fault capture pulse
	input  wire logic                  rd_start,   // Begin block read pulse
	input  wire logic                  rd_next,    // Advance to next byte pulse
	output logic [7:0]                 rd_data,    // Current stream byte
	output logic                       rd_valid,   // Stream byte valid
	output logic                       rd_last,    // Current byte is last of block
	output logic [5:0]                 rd_pos,     // Loop position of current cyclic byte
	output logic                       lock        // Ring locked after a fault
);
	typedef struct packed {
		logic [fault_record_pkg::RING_LEN-1:0][7:0] ring;
		logic [7:0]        wi;
		logic [5:0]        pos;
		logic [7:0]        cnt;
		logic              lock;
		logic [7:0]        snap_wi;
		logic [5:0]        snap_pos;
		logic [7:0]        snap_cnt;
		logic [23:0][7:0]  snap_st;
		logic              act;
		logic [7:0]        idx;
		logic [7:0]        data;
		logic [5:0]        rpos;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Live value for a loop position; input and temperature groups break the channel stride
	function automatic logic [7:0] loop_byte(input logic [5:0] p);
		logic [5:0] rel;
		logic [5:0] cb;
		logic [2:0] ch;
		logic [2:0] f;
		logic [7:0] b;
		rel = p;
		cb  = 6'h00;
		b   = fault_record_pkg::FILL_BYTE;
		if (p >= fault_record_pkg::GRP4_POS) begin
			rel = p - fault_record_pkg::GRP4_POS;
			cb  = 6'h04;
		end else if (p >= fault_record_pkg::GRP2_POS && p < fault_record_pkg::TEMP_POS) begin
			rel = p - fault_record_pkg::GRP2_POS;
			cb  = 6'h02;
		end
		ch = 3'(cb + rel / fault_record_pkg::CH_BYTES);
		f  = 3'(rel % fault_record_pkg::CH_BYTES);
		if (p >= fault_record_pkg::VIN_POS && p < fault_record_pkg::GRP2_POS) begin
			unique case (p - fault_record_pkg::VIN_POS)
				6'h00:   b = vin_rd[7:0];
				6'h01:   b = vin_rd[15:8];
				default: b = vin_st;
			endcase
		end else if (p >= fault_record_pkg::TEMP_POS && p < fault_record_pkg::GRP4_POS) begin
			unique case (p - fault_record_pkg::TEMP_POS)
				6'h00:   b = temp_rd[7:0];
				6'h01:   b = temp_rd[15:8];
				default: b = temp_st;
			endcase
		end else begin
			unique case (f)
				3'h0:    b = vout_rd[ch][7:0];
				3'h1:    b = vout_rd[ch][15:8];
				3'h2:    b = vout_st[ch];
				3'h3:    b = mfr_st[ch];
				default: b = ext_st[ch][7:0];
			endcase
		end
		return b;
	endfunction

	always_comb begin
		logic [7:0] n;
		logic [7:0] d;
		logic [5:0] dd;
		logic [8:0] rix;
		logic [7:0] nb;
		logic [5:0] np;
		n   = 8'h00;
		d   = 8'h00;
		dd  = 6'h00;
		rix = 9'h000;
		nb  = fault_record_pkg::FILL_BYTE;
		np  = s_q.rpos;
		s_d = s_q;
		// Block read stream: index 0 is the count, index k is record byte k-1
		if (rd_start && !s_q.act) begin
			s_d.act  = 1'b1;
			s_d.idx  = 8'h00;
			s_d.data = fault_record_pkg::BLK_COUNT;
		end else if (s_q.act && rd_next) begin
			if (s_q.idx == fault_record_pkg::STREAM_END) begin
				s_d.act  = 1'b0;
				s_d.lock = 1'b0;
			end else begin
				n = s_q.idx;
				d = n - fault_record_pkg::CYC_FIRST;
				dd = 6'(d % 8'(fault_record_pkg::LOOP_LEN));
				rix = (s_q.snap_wi >= d) ? 9'(s_q.snap_wi - d)
					: 9'({1'b0, s_q.snap_wi} + 9'(fault_record_pkg::RING_LEN) - {1'b0, d});
				if (n == 8'h00) begin
					nb = {2'b00, s_q.snap_pos};
				end else if (n == 8'h01) begin
					nb = (s_q.snap_cnt == 8'(fault_record_pkg::RING_LEN))
						? fault_record_pkg::ALL_VALID : s_q.snap_cnt;
				end else if (n >= fault_record_pkg::ST_BASE && n < fault_record_pkg::CYC_FIRST) begin
					nb = s_q.snap_st[5'(n - fault_record_pkg::ST_BASE)];
				end else if (n >= fault_record_pkg::CYC_FIRST && n <= fault_record_pkg::CYC_LAST) begin
					nb = s_q.ring[rix[7:0]];
					// Older entries sit at lower positions, wrapping below zero
					np = (s_q.snap_pos >= dd) ? s_q.snap_pos - dd
						: s_q.snap_pos + 6'(fault_record_pkg::LOOP_LEN) - dd;
				end
				// Bytes 2..47 and 238..254 fall through as filler
				s_d.idx  = s_q.idx + 8'h01;
				s_d.data = nb;
				s_d.rpos = np;
			end
		end
		if (adc_done && !s_q.lock) begin
			s_d.pos = (s_q.pos == fault_record_pkg::POS_MAX) ? 6'h00 : s_q.pos + 6'h01;
			s_d.wi  = (s_q.wi == 8'(fault_record_pkg::RING_LEN - 1)) ? 8'h00 : s_q.wi + 8'h01;
			s_d.ring[s_d.wi] = loop_byte(s_d.pos);
			if (s_q.cnt != 8'(fault_record_pkg::RING_LEN)) begin
				s_d.cnt = s_q.cnt + 8'h01;
			end
		end
		// Capture sits after the read end, yet a fault in that cycle is ignored while s_q.lock is still set
		if (fault_trig && !s_q.lock) begin
			s_d.lock     = 1'b1;
			s_d.snap_wi  = s_d.wi;
			s_d.snap_pos = s_d.pos;
			s_d.snap_cnt = s_d.cnt;
			for (int c = 0; c < fault_record_pkg::CH_N; c++) begin
				s_d.snap_st[3*c]     = vout_st[c];
				s_d.snap_st[3*c + 1] = mfr_st[c];
				s_d.snap_st[3*c + 2] = ext_st[c][7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q      <= '0;
			s_q.wi   <= fault_record_pkg::WI_RESET;
			s_q.pos  <= fault_record_pkg::POS_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data  = s_q.data;
	assign rd_valid = s_q.act;
	// Lock clears only when the final byte is taken, so a cut read leaves the record held
	assign rd_last  = s_q.act && (s_q.idx == fault_record_pkg::STREAM_END);
	assign rd_pos   = s_q.rpos;
	assign lock     = s_q.lock;

	default clocking cb_main @(posedge clk); endclocking
	default disable iff (!nrst);

	AST_COUNT_FIRST: assert property (rd_start && !rd_valid |=>
		rd_valid && rd_data == 8'hFF)
		else $error("block count not 0xFF");
	AST_INDEX_BYTE: assert property (rd_valid && s_q.idx == 8'h01 |->
		rd_data == {2'b00, s_q.snap_pos})
		else $error("first data byte not newest index");
	AST_VALID_COUNT: assert property (rd_valid && s_q.idx == 8'h02 |->
		rd_data == ((s_q.snap_cnt == 8'hA6) ? 8'hFF : s_q.snap_cnt))
		else $error("valid count byte wrong");
	AST_CYC_START: assert property (rd_valid && s_q.idx == 8'h49 |->
		rd_data == s_q.ring[s_q.snap_wi] && rd_pos == s_q.snap_pos)
		else $error("byte 72 not newest ring entry");
	AST_FILLER: assert property (rd_valid && s_q.idx >= 8'hEF |-> rd_data == 8'h00)
		else $error("reserved byte not filler");
	AST_POS_DEC: assert property (
		rd_valid && s_q.idx > 8'h49 && s_q.idx < 8'hEF && $changed(s_q.idx)
		|-> rd_pos == (($past(rd_pos) == 6'h00) ? 6'h2D : $past(rd_pos) - 6'h01))
		else $error("loop position not decremented");
	AST_POS_WRAP: assert property (adc_done && !lock && s_q.pos == 6'h2D |=>
		s_q.pos == 6'h00)
		else $error("loop position did not wrap at 45");
	AST_LOCK_FREEZE: assert property (lock && !rd_valid |=>
		$stable(s_q.wi) && $stable(s_q.ring))
		else $error("ring changed while locked");
	// A taken pulse writes one position past the current one, so 10 lands at 11
	AST_REFRESH: assert property (adc_done && !lock && s_q.pos == 6'h0A |=>
		s_q.ring[s_q.wi] == $past(vin_rd[15:8]))
		else $error("position 11 not input voltage high byte");
	AST_EXT_LOW: assert property (fault_trig && !lock |=>
		s_q.snap_st[2] == $past(ext_st[0][7:0]))
		else $error("extended status low byte not captured");

	COV_FAULT: cover property (fault_trig && !lock);
	COV_READ_END: cover property (rd_last && rd_next);
	COV_FULL_RING: cover property (s_q.cnt == 8'hA6 && fault_trig);
	COV_POS_WRAP_READ: cover property (rd_valid && rd_pos == 6'h2D && s_q.idx > 8'h49);
endmodule
`default_nettype wire

// File: test/block_reader.sv
// Host side model that fetches the fault record with one block read
`timescale 1ns/1ps
`default_nettype none
module block_reader (
	input  wire logic       clk,      // Bench clock
	input  wire logic [7:0] rd_data,  // Stream byte
	input  wire logic       rd_valid, // Read in progress
	input  wire logic       rd_last,  // Final byte flag
	input  wire logic [5:0] rd_pos,   // Loop position of cyclic byte
	output logic            rd_start, // Start pulse
	output logic            rd_next   // Advance pulse
);
	logic [7:0] got [0:255];
	logic [5:0] pos [0:255];
	logic       got_last;
	initial begin
		rd_start = 1'b0;
		rd_next = 1'b0;
	end
	// Slow mode idles a cycle between bytes, as a stretched bus transfer would
	task automatic fetch(input bit slow);
		@(posedge clk);
		rd_start <= 1'b1;
		@(posedge clk);
		rd_start <= 1'b0;
		@(posedge clk iff rd_valid);
		for (int k = 0; k < 256; k++) begin
			rd_next <= 1'b1;
			@(posedge clk);
			got[k] = rd_data;
			pos[k] = rd_pos;
			got_last = rd_last;
			if (slow) begin
				rd_next <= 1'b0;
				@(posedge clk);
			end
		end
		rd_next <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: test/test_fault_record_fmt.sv
// Self-checking bench for the fault record block formatter
`timescale 1ns/1ps
`default_nettype none
module test_fault_record_fmt;
	localparam int LL = fault_record_pkg::LOOP_LEN;
	localparam int RL = fault_record_pkg::RING_LEN;
	logic             clk = 1'b0;
	logic             nrst = 1'b0;
	logic [7:0][15:0] vout_rd, ext_st;
	logic [7:0][7:0]  vout_st, mfr_st;
	logic [15:0]      vin_rd, temp_rd;
	logic [7:0]       vin_st, temp_st, rd_data;
	logic             adc_done = 1'b0, fault_trig = 1'b0, rd_start, rd_next;
	logic             rd_valid, rd_last, lock;
	logic [5:0]       rd_pos;
	int               fails = 0, n_checks = 0, w = 0;
	always #5 clk = ~clk;
	fault_record_fmt fault_record_fmt_i (.clk(clk), .nrst(nrst), .vout_rd(vout_rd),
		.vout_st(vout_st), .mfr_st(mfr_st), .ext_st(ext_st), .vin_rd(vin_rd), .vin_st(vin_st),
		.temp_rd(temp_rd), .temp_st(temp_st), .adc_done(adc_done), .fault_trig(fault_trig),
		.rd_start(rd_start), .rd_next(rd_next), .rd_data(rd_data), .rd_valid(rd_valid),
		.rd_last(rd_last), .rd_pos(rd_pos), .lock(lock));
	block_reader block_reader_i (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid),
		.rd_last(rd_last), .rd_pos(rd_pos), .rd_start(rd_start), .rd_next(rd_next));
	// Each live byte carries its own loop position and a stamp of the conversion
	function automatic logic [7:0] bt(int s, int p);
		return {2'(s), 6'(p)};
	endfunction
	function automatic int base(int c);
		return c * 5 + (c > 1 ? 3 : 0) + (c > 3 ? 3 : 0);
	endfunction
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic set_in(int s);
		for (int c = 0; c < 8; c++) begin
			vout_rd[c] <= {bt(s, base(c) + 1), bt(s, base(c))};
			vout_st[c] <= bt(s, base(c) + 2);
			mfr_st[c] <= bt(s, base(c) + 3);
			ext_st[c] <= {8'hEE, bt(s, base(c) + 4)};
		end
		vin_rd <= {bt(s, 11), bt(s, 10)};
		vin_st <= bt(s, 12);
		temp_rd <= {bt(s, 24), bt(s, 23)};
		temp_st <= bt(s, 25);
	endtask
	// Held conversions carry other data so a stored one would show up
	task automatic conv(int n, bit trig, bit held);
		for (int i = 0; i < n; i++) begin
			set_in(held ? w + 2 : w);
			adc_done <= 1'b1;
			fault_trig <= trig && i == n - 1;
			@(posedge clk);
			if (!held) w++;
		end
		adc_done <= 1'b0;
		fault_trig <= 1'b0;
	endtask
	task automatic chk_lock(logic exp);
		@(negedge clk);
		chk("lock", {7'h00, exp}, {7'h00, lock});
		chk("rd_valid", 8'h00, {7'h00, rd_valid});
		@(posedge clk);
	endtask
	task automatic check_read(bit slow, int sf);
		int v, p;
		block_reader_i.fetch(slow);
		v = w < RL ? w : RL;
		chk("count", 8'hFF, block_reader_i.got[0]);
		chk("newest", 8'((w - 1) % LL), block_reader_i.got[1]);
		chk("valid", w < RL ? 8'(w) : 8'hFF, block_reader_i.got[2]);
		for (int k = 0; k < 24; k++) begin
			chk("status", bt(sf, base(k / 3) + 2 + k % 3), block_reader_i.got[49+k]);
		end
		for (int k = 0; k < RL; k++) begin
			p = (w - 1 - k + 4 * LL) % LL;
			chk("cyclic", k<v ? bt(w-1-k, p) : 8'h00, block_reader_i.got[73+k]);
			chk("pos", 8'(p), {2'b00, block_reader_i.pos[73+k]});
		end
		for (int k = 239; k < 256; k++) begin
			chk("fill", 8'h00, block_reader_i.got[k]);
		end
		chk("last", 8'h01, {7'h00, block_reader_i.got_last});
		chk_lock(1'b0);
	endtask
	task automatic t_partial();
		conv(20, 1'b0, 1'b0);
		// A spare edge keeps this fault apart from the last conversion
		@(posedge clk);
		fault_trig <= 1'b1;
		@(posedge clk);
		fault_trig <= 1'b0;
		chk_lock(1'b1);
		conv(5, 1'b1, 1'b1);
		check_read(1'b0, 19);
	endtask
	task automatic t_wrap();
		conv(190, 1'b1, 1'b0);
		chk_lock(1'b1);
		check_read(1'b1, w - 1);
	endtask
	initial begin
		set_in(0);
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_partial();
		t_wrap();
		report_and_stop();
	end
	initial begin
		#50000;
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
